// ===== src/bpl_link.sv
// Sensor end of the biphase programming link.
// Assumes synchronous pin inputs and an external memory port.
`timescale 1ns/100ps
`include "bpl_params.svh"
module bpl_link
  import bpl_pkg::*;
#(
  parameter int BIT_CYC = `BPL_BIT_CYC,
  parameter int BIT_MIN_CYC = `BPL_BIT_MIN_CYC,
  parameter int BIT_MAX_CYC = `BPL_BIT_MAX_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic supply_mode,
  input wire logic sup_rx,
  input wire logic out_pin_in,
  output logic out_pin_out,
  output logic out_pin_oe_b,
  output logic [7:0] mem_addr,
  output logic mem_wr,
  output logic mem_rd,
  output logic [15:0] write_payload,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_permit,
  input wire logic nv_busy,
  output logic [1:0] base_addr,
  output logic cmd_error,
  output logic parity_error,
  output logic crc_error
);
  localparam int CW = $clog2(BIT_MAX_CYC * 6 + 1);
  localparam logic [CW-1:0] IDLE_CYC = CW'(BIT_MAX_CYC * 2);
  localparam logic [CW-1:0] RESP_CYC = CW'(BIT_CYC * 2);
  localparam logic [CW-1:0] TX_BIT = CW'(BIT_CYC);
  localparam logic [CW-1:0] TX_HALF = CW'(BIT_CYC / 2);

  // Receive pin select; out pin unless supply_mode selects sup_rx
  logic rx_in;
  assign rx_in = supply_mode ? sup_rx : out_pin_in;
  logic rx_d_r;
  logic [CW-1:0] since_r;
  logic [CW-1:0] bit_len_r;
  logic [CW-1:0] bit_cnt_r;
  logic half_seen_r;
  logic in_frame_r;
  logic [5:0] nbits_r;
  logic [29:0] sh_r;
  logic edge_in;
  logic tx_busy;
  assign edge_in = (rx_in != rx_d_r) && !tx_busy;

  // Bit recovery: every bit ends with a toggle; a one has one inside
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_d_r <= 1'b1;
      since_r <= '0;
      bit_len_r <= CW'(BIT_CYC);
      bit_cnt_r <= '0;
      half_seen_r <= 1'b0;
      in_frame_r <= 1'b0;
      nbits_r <= '0;
      sh_r <= '0;
    end else begin
      rx_d_r <= rx_in;
      if (since_r != '1) begin
        since_r <= since_r + 1'b1;
      end
      if (in_frame_r && since_r >= IDLE_CYC) begin
        in_frame_r <= 1'b0;
      end
      if (edge_in) begin
        since_r <= '0;
        if (!in_frame_r) begin
          in_frame_r <= 1'b1;
          bit_cnt_r <= '0;
          nbits_r <= '0;
          half_seen_r <= 1'b0;
        end else begin
          bit_cnt_r <= bit_cnt_r + since_r + 1'b1;
          if (bit_cnt_r + since_r >=
              CW'(BIT_MIN_CYC * 3 / 4)) begin
            sh_r <= {sh_r[28:0], half_seen_r};
            nbits_r <= nbits_r + 1'b1;
            bit_len_r <= bit_cnt_r + since_r + 1'b1;
            bit_cnt_r <= '0;
            half_seen_r <= 1'b0;
          end else if (bit_cnt_r + since_r >=
                       CW'(BIT_MIN_CYC * `BPL_HALF_MIN_PCT / 100 / 2)) begin
            half_seen_r <= 1'b1;
          end
        end
      end
    end
  end

  // End of telegram: silence for two bits; host keeps three
  logic frame_done;
  assign frame_done = in_frame_r && since_r == IDLE_CYC;

  function automatic logic [3:0] crc_step(input logic [3:0] c,
                                          input logic b);
    logic fb;
    fb = c[3] ^ b;
    crc_step = {c[2:0], 1'b0} ^ {2'b00, fb, fb};
  endfunction

  // Frame checks over captured bits, first bit oldest
  logic [29:0] wr_f;
  logic [9:0] rd_f;
  logic [3:0] crc_c;
  logic frm_ok;
  logic par_ok;
  logic crc_ok;
  bpl_req_s req;
  always_comb begin
    wr_f = sh_r;
    rd_f = sh_r[9:0];
    crc_c = `BPL_CRC_INIT;
    for (int i = 28; i >= 4; i--) begin
      crc_c = crc_step(crc_c, wr_f[i]);
    end
    if (nbits_r == 6'(`BPL_RD_BITS)) begin
      req.command_field = rd_f[8:6];
      req.offset = rd_f[5:1];
      par_ok = ^rd_f[8:0];
      frm_ok = !sh_r[9] && req.command_field == `BPL_CMD_READ;
      crc_ok = 1'b1;
      req.payload_word = '0;
    end else begin
      req.command_field = wr_f[28:26];
      req.offset = wr_f[25:21];
      par_ok = ^wr_f[28:20];
      frm_ok = nbits_r == 6'(`BPL_WR_BITS) && !sh_r[29];
      crc_ok = crc_c == wr_f[3:0];
      req.payload_word = wr_f[19:4];
    end
  end

  // Command execution
  logic [1:0] base_r;
  logic tx_req;
  logic fifo_ready;
  bpl_tx_s tx_item;
  logic [7:0] eff;
  assign eff = {1'b0, base_r, 5'h00} + {3'h0, req.offset};
  logic rd_pend_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_r <= `BPL_BASE_RST;
      mem_addr <= '0;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      write_payload <= '0;
      cmd_error <= 1'b0;
      parity_error <= 1'b0;
      crc_error <= 1'b0;
      rd_pend_r <= 1'b0;
      tx_req <= 1'b0;
      tx_item <= '0;
    end else begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      tx_req <= 1'b0;
      // A lone edge is line settling, not a telegram; flags stay
      if (frame_done && nbits_r != 6'h00) begin
        parity_error <= !par_ok;
        crc_error <= !crc_ok;
        cmd_error <= 1'b0;
        if (frm_ok && par_ok && crc_ok) begin
          mem_addr <= eff;
          case (req.command_field)
            `BPL_CMD_BASE: begin
              base_r <= req.payload_word[1:0];
              tx_item <= '{is_ack: 1'b1, payload_word: '0};
              tx_req <= 1'b1;
            end
            `BPL_CMD_WRITE: begin
              if (mem_permit && !nv_busy) begin
                mem_wr <= 1'b1;
                write_payload <= req.payload_word;
                tx_item <= '{is_ack: 1'b1, payload_word: '0};
                tx_req <= 1'b1;
              end else begin
                cmd_error <= 1'b1;
              end
            end
            `BPL_CMD_READ: begin
              mem_rd <= 1'b1;
              rd_pend_r <= 1'b1;
            end
            default: cmd_error <= 1'b1;
          endcase
        end
      end
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        if (mem_permit) begin
          tx_item <= '{is_ack: 1'b0, payload_word: mem_rdata};
          tx_req <= 1'b1;
        end else begin
          cmd_error <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_addr <= `BPL_BASE_RST;
    end else begin
      base_addr <= base_r;
    end
  end

  // Answer queue; a full queue drops the answer
  logic q_valid;
  logic q_ready;
  bpl_tx_s q_item;
  bpl_fifo #(.WIDTH($bits(bpl_tx_s)), .DEPTH(8)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(tx_req),
    .in_ready(fifo_ready),
    .in_data(tx_item),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_item)
  );

  // Transmitter on its own fixed bit time
  bpl_tx_e st_r;
  logic [CW-1:0] tc_r;
  logic [4:0] ti_r;
  logic [19:0] txsh_r;
  logic [3:0] txcrc_r;
  logic lvl_r;
  assign tx_busy = st_r != BPL_IDLE && st_r != BPL_WAIT;
  assign q_ready = st_r == BPL_IDLE && !in_frame_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= BPL_IDLE;
      tc_r <= '0;
      ti_r <= '0;
      txsh_r <= '0;
      txcrc_r <= `BPL_CRC_INIT;
      lvl_r <= 1'b1;
    end else begin
      tc_r <= tc_r + 1'b1;
      case (st_r)
        BPL_IDLE: begin
          tc_r <= '0;
          if (q_valid && q_ready) begin
            txsh_r <= {q_item.payload_word, 4'h0};
            txcrc_r <= `BPL_CRC_INIT;
            ti_r <= '0;
            st_r <= q_item.is_ack ? BPL_ACKL : BPL_WAIT;
          end
        end
        BPL_WAIT: begin
          // Two bits after the telegram end gives start at 4 bits
          if (tc_r == RESP_CYC - 1'b1) begin
            tc_r <= '0;
            st_r <= BPL_DATA;
            lvl_r <= !lvl_r;
          end
        end
        BPL_DATA, BPL_CRC: begin
          if (tc_r == TX_HALF && txsh_r[19]) begin
            lvl_r <= !lvl_r;
          end
          if (tc_r == TX_BIT - 1'b1) begin
            tc_r <= '0;
            lvl_r <= !lvl_r;
            ti_r <= ti_r + 1'b1;
            if (st_r == BPL_DATA && ti_r != 5'h0) begin
              txcrc_r <= crc_step(txcrc_r, txsh_r[19]);
            end
            if (ti_r == 5'h0) begin
              ti_r <= 5'h1;
            end else begin
              txsh_r <= {txsh_r[18:0], 1'b0};
            end
            if (ti_r == 5'd16) begin
              st_r <= BPL_CRC;
              txsh_r <= {crc_step(txcrc_r, txsh_r[19]), 16'h0000};
            end
            if (ti_r == 5'd20) begin
              st_r <= BPL_GAP;
              lvl_r <= 1'b1;
            end
          end
          if (ti_r == 5'h0 && tc_r == TX_HALF) begin
            lvl_r <= lvl_r;
          end
        end
        BPL_ACKL: begin
          // Space, one bit low pulse, space
          if (tc_r == TX_BIT) begin
            lvl_r <= 1'b0;
          end
          if (tc_r == TX_BIT + TX_BIT) begin
            lvl_r <= 1'b1;
            tc_r <= '0;
            st_r <= BPL_GAP;
          end
        end
        BPL_GAP: begin
          if (tc_r == CW'(BIT_CYC * `BPL_TX_GAP_BITS)) begin
            st_r <= BPL_IDLE;
          end
        end
        default: st_r <= BPL_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_pin_out <= 1'b1;
      out_pin_oe_b <= 1'b1;
    end else begin
      out_pin_out <= lvl_r;
      out_pin_oe_b <= !tx_busy;
    end
  end
endmodule

// ===== src/bpl_params.svh
// Constants of the biphase programming link: timing, frame fields, codes.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef BPL_PARAMS_SVH
`define BPL_PARAMS_SVH
`define BPL_CLK_MHZ 125
`define BPL_BIT_US 1024
`define BPL_HOST_BIT_MIN_US 972
`define BPL_HOST_BIT_MAX_US 1075
`define BPL_HALF_MIN_PCT 45
`define BPL_HALF_MAX_PCT 55
`define BPL_HOST_GAP_BITS 3
`define BPL_TX_GAP_BITS 2
`define BPL_RESP_MIN_BITS 1
`define BPL_RESP_MAX_BITS 5
`define BPL_BIT_CYC (`BPL_BIT_US * `BPL_CLK_MHZ)
`define BPL_BIT_MIN_CYC (`BPL_HOST_BIT_MIN_US * `BPL_CLK_MHZ)
`define BPL_BIT_MAX_CYC (`BPL_HOST_BIT_MAX_US * `BPL_CLK_MHZ)
`define BPL_CMD_READ 3'h1
`define BPL_CMD_BASE 3'h3
`define BPL_CMD_WRITE 3'h6
`define BPL_HDR_BITS 10
`define BPL_WR_BITS 30
`define BPL_RD_BITS 10
`define BPL_CRC_INIT 4'h0
`define BPL_BASE_RST 2'h0
`endif

// ===== src/bpl_pkg.sv
// Types of the biphase programming link.
// Assumes bpl_params.svh is on the include path.
package bpl_pkg;
  typedef struct packed {
    logic [2:0] command_field;
    logic [4:0] offset;
    logic [15:0] payload_word;
  } bpl_req_s;
  typedef struct packed {
    logic is_ack;
    logic [15:0] payload_word;
  } bpl_tx_s;
  typedef enum logic [5:0] {
    BPL_IDLE = 6'h01,
    BPL_WAIT = 6'h02,
    BPL_DATA = 6'h04,
    BPL_CRC = 6'h08,
    BPL_ACKL = 6'h10,
    BPL_GAP = 6'h20
  } bpl_tx_e;
endpackage

// ===== src/bpl_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data come from a register.
`timescale 1ns/100ps
module bpl_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (cnt_r != '0) && (!out_valid || out_ready);
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Output stage register; holds until taken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_r[rp_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ===== tb/bpl_link_monitor.sv
// Port checker of the sensor link: strobes, gating, reply timing.
// Assumes it is bound onto bpl_link and given its bit-time parameter.
`timescale 1ns/100ps
module bpl_link_monitor #(
  parameter int BIT_CYC = 64
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic out_pin_out,
  input wire logic out_pin_oe_b,
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic mem_permit,
  input wire logic nv_busy,
  input wire logic [1:0] base_addr,
  input wire logic cmd_error,
  input wire logic parity_error,
  input wire logic crc_error
);
  localparam int RESP_MAX = 5 * BIT_CYC;
  logic [15:0] run_r;
  logic [15:0] idle_r;
  logic last_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Both counts saturate, so a long idle never wraps into a short one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= 16'h0000;
      idle_r <= 16'h0000;
      last_r <= 1'b1;
    end else begin
      last_r <= out_pin_out;
      run_r <= (out_pin_out != last_r) ? 16'h0001 : run_r + {15'h0, ~&run_r};
      idle_r <= !out_pin_oe_b ? 16'h0000 : idle_r + {15'h0, ~&idle_r};
    end
  end
  a_wr_one_cycle: assert property (mem_wr |=> !mem_wr)
    else $error("write strobe longer than one cycle");
  a_rd_one_cycle: assert property (mem_rd |=> !mem_rd)
    else $error("read strobe longer than one cycle");
  a_wr_not_busy: assert property (mem_wr |-> !$past(nv_busy))
    else $error("write stored during memory programming");
  a_wr_permitted: assert property (mem_wr |-> $past(mem_permit))
    else $error("write stored to a refused address");
  a_wr_eff_addr: assert property (
    mem_wr |-> mem_addr[6:5] == base_addr && !mem_addr[7])
    else $error("write address does not carry the base");
  a_wr_acked: assert property (
    mem_wr |-> ##[1:RESP_MAX] !out_pin_oe_b)
    else $error("no acknowledge after a stored write");
  a_wr_no_flag: assert property (
    mem_wr |=> !parity_error && !crc_error && !cmd_error)
    else $error("write stored although an error was flagged");
  a_err_silent: assert property (
    (parity_error || crc_error || cmd_error) |-> out_pin_oe_b)
    else $error("sensor drives the pin after a faulty telegram");
  a_half_bit_min: assert property (
    (!out_pin_oe_b && out_pin_out != last_r) |-> run_r >= BIT_CYC / 2 - 2)
    else $error("sent level shorter than half a bit");
  a_frame_gap: assert property (
    $fell(out_pin_oe_b) |-> idle_r >= 2 * BIT_CYC - 2)
    else $error("sent frames closer than two bits");
  a_base_hold: assert property (!out_pin_oe_b |-> $stable(base_addr))
    else $error("base changed while answering");
  c_read_reply: cover property (mem_rd ##[1:RESP_MAX] !out_pin_oe_b);
  c_base_set: cover property ($changed(base_addr));
  c_wr_based: cover property (mem_wr && mem_addr[6:5] != 2'h0);
endmodule
bind bpl_link bpl_link_monitor #(.BIT_CYC(BIT_CYC)) bpl_link_monitor_i (
  .clk, .rst_b, .out_pin_out, .out_pin_oe_b, .mem_addr, .mem_wr, .mem_rd,
  .mem_permit, .nv_busy, .base_addr, .cmd_error, .parity_error, .crc_error);

// ===== tb/bpl_host.sv
// Host programmer model: builds and sends biphase telegrams.
// Assumes the bench routes lvl to the chosen sensor input.
`timescale 1ns/100ps
module bpl_host #(
  parameter int BIT_CYC = 64
) (
  input wire logic clk,
  output logic lvl
);
  initial lvl = 1'b1;
  // Leading zeros leave a zero-seeded sum unchanged
  function automatic logic [3:0] crc4(logic [24:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 24; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'h3 : 4'h0);
    end
    return c;
  endfunction
  task automatic half(logic t);
    @(posedge clk);
    if (t) lvl <= ~lvl;
    repeat (BIT_CYC / 2 - 1) @(posedge clk);
  endtask
  // fl[0] spoils parity, fl[1] spoils the check sum
  task automatic send(logic [2:0] cmd, logic [4:0] adr, logic [15:0] d,
                      logic wr, logic [1:0] fl);
    logic [29:0] v;
    logic p;
    p = ~^{cmd, adr} ^ fl[0];
    v = {1'b0, cmd, adr, p, d, 4'h0};
    v[3:0] = crc4(v[28:4]) ^ {fl[1], 3'h0};
    // Back to idle high; the lone edge dies out within the gap
    if (lvl == 1'b0) begin
      @(posedge clk);
      lvl <= 1'b1;
    end
    repeat (3 * BIT_CYC) @(posedge clk);
    for (int i = 29; i >= (wr ? 0 : 20); i--) begin
      half(1'b1);
      half(v[i]);
    end
    // Closing boundary toggle, whatever level it leaves
    @(posedge clk);
    lvl <= ~lvl;
  endtask
endmodule

// ===== tb/bpl_link_tb.sv
// Bench of the sensor link: host model, memory model, scenarios.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
module bpl_link_tb;
  localparam int B = 64;
  logic clk, rst_b, supply_mode, nv_busy, permit, host_lvl;
  logic out_pin_out, out_pin_oe_b, mem_wr, mem_rd;
  logic cmd_error, parity_error, crc_error;
  logic [7:0] mem_addr;
  logic [15:0] write_payload;
  logic [1:0] base_addr;
  logic [15:0] mem [256];
  int n_fail, comparisons, n_wr;
  wire pin = !out_pin_oe_b ? out_pin_out : (supply_mode | host_lvl);
  bpl_link #(.BIT_CYC(B), .BIT_MIN_CYC(60), .BIT_MAX_CYC(68)) bpl_link_i (
    .clk, .rst_b, .supply_mode, .sup_rx(host_lvl | !supply_mode),
    .out_pin_in(pin), .out_pin_out, .out_pin_oe_b, .mem_addr, .mem_wr,
    .mem_rd, .write_payload, .mem_rdata(mem[mem_addr]), .mem_permit(permit),
    .nv_busy, .base_addr, .cmd_error, .parity_error, .crc_error);
  bpl_host #(.BIT_CYC(B)) bpl_host_i (.clk, .lvl(host_lvl));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= write_payload;
      n_wr <= n_wr + 1;
    end
  end
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // nb of 0 awaits the acknowledge, else decodes nb sent bits
  task automatic reply(int nb, output logic ok, output logic [20:0] r);
    int c;
    logic a;
    ok = 1'b0;
    r = '0;
    c = 0;
    while (out_pin_oe_b !== 1'b0 && c < 6 * B) begin
      @(negedge clk);
      c++;
    end
    if (c >= 6 * B) return;
    ok = 1'b1;
    chk(16'(c >= B && c <= 5 * B), 16'h1);
    if (nb == 0) begin
      repeat (B / 2) @(negedge clk);
      chk(out_pin_out, 16'h1);
      repeat (B) @(negedge clk);
      chk(out_pin_out, 16'h0);
      repeat (B) @(negedge clk);
      chk(out_pin_out, 16'h1);
    end else begin
      c = 0;
      while (out_pin_out === 1'b1 && c < 3 * B) begin
        @(negedge clk);
        c++;
      end
      for (int i = 0; i < nb; i++) begin
        repeat (B / 4) @(negedge clk);
        a = out_pin_out;
        repeat (B / 2) @(negedge clk);
        r = {r[19:0], a ^ out_pin_out};
        repeat (B / 4) @(negedge clk);
      end
    end
  endtask
  task automatic t_write(logic [4:0] a, logic [15:0] d, logic [7:0] ea);
    logic ok;
    logic [20:0] r;
    int w;
    w = n_wr;
    bpl_host_i.send(3'h6, a, d, 1'b1, 2'h0);
    reply(0, ok, r);
    chk(ok, 16'h1);
    chk(16'(n_wr - w), 16'h1);
    chk(mem[ea], d);
  endtask
  task automatic t_read(logic [4:0] a, logic [15:0] d);
    logic ok;
    logic [20:0] r;
    bpl_host_i.send(3'h1, a, 16'h0000, 1'b0, 2'h0);
    reply(21, ok, r);
    chk(ok, 16'h1);
    chk(r[20], 16'h0);
    chk(r[19:4], d);
    chk(r[3:0], bpl_host_i.crc4({9'h000, d}));
  endtask
  task automatic t_base(logic [15:0] d, logic [1:0] b);
    logic ok;
    logic [20:0] r;
    int w;
    w = n_wr;
    bpl_host_i.send(3'h3, 5'h0a, d, 1'b1, 2'h0);
    reply(0, ok, r);
    chk(ok, 16'h1);
    chk(base_addr, b);
    chk(16'(n_wr - w), 16'h0);
  endtask
  // Faulty or refused telegram: no answer, nothing stored, flag raised
  task automatic t_refuse(logic [2:0] cmd, logic wr, logic [1:0] fl,
                          logic busy, logic pm, logic [2:0] f);
    logic ok;
    logic [20:0] r;
    logic [1:0] b;
    int w;
    b = base_addr;
    w = n_wr;
    @(posedge clk);
    nv_busy <= busy;
    permit <= pm;
    bpl_host_i.send(cmd, 5'h05, 16'h1234, wr, fl);
    reply(wr ? 0 : 21, ok, r);
    chk(ok, 16'h0);
    chk(16'(n_wr - w), 16'h0);
    chk({parity_error, crc_error, cmd_error}, f);
    chk(base_addr, b);
    @(posedge clk);
    nv_busy <= 1'b0;
    permit <= 1'b1;
  endtask
  initial begin
    rst_b = 1'b0;
    supply_mode = 1'b0;
    nv_busy = 1'b0;
    permit = 1'b1;
    n_fail = 0;
    comparisons = 0;
    n_wr = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({out_pin_out, out_pin_oe_b, base_addr, cmd_error, parity_error,
         crc_error}, 16'h60);
    t_write(5'h05, 16'ha5c3, 8'h05);
    t_read(5'h05, 16'ha5c3);
    t_base(16'hfffe, 2'h2);
    t_refuse(3'h3, 1'b1, 2'h2, 1'b0, 1'b1, 3'h2);
    t_write(5'h1f, 16'h3c01, 8'h5f);
    t_read(5'h1f, 16'h3c01);
    t_refuse(3'h6, 1'b1, 2'h1, 1'b0, 1'b1, 3'h4);
    t_refuse(3'h6, 1'b1, 2'h2, 1'b0, 1'b1, 3'h2);
    t_refuse(3'h2, 1'b1, 2'h0, 1'b0, 1'b1, 3'h1);
    t_refuse(3'h6, 1'b1, 2'h0, 1'b1, 1'b1, 3'h1);
    t_refuse(3'h6, 1'b1, 2'h0, 1'b0, 1'b0, 3'h1);
    t_refuse(3'h1, 1'b0, 2'h0, 1'b0, 1'b0, 3'h1);
    t_base(16'h0001, 2'h1);
    @(posedge clk);
    supply_mode <= 1'b1;
    t_write(5'h02, 16'h8001, 8'h22);
    final_report;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    final_report;
  end
endmodule
